/* gpcfg_map.vh */
// register offsets, field positions, reset values and counts of the output-pin and fifo config
`ifndef GPCFG_MAP_VH
`define GPCFG_MAP_VH

`define GPCFG_ADDR_W          6
`define GPCFG_OFS_PIN1        6'h01
`define GPCFG_OFS_PIN0        6'h02
`define GPCFG_OFS_FIFO        6'h03
`define GPCFG_OFS_TEST_B      6'h2c
`define GPCFG_OFS_TEST_A      6'h2d

`define GPCFG_RST_PIN1        8'h2e
`define GPCFG_RST_PIN0        8'h3f
`define GPCFG_RST_FIFO        8'h07
`define GPCFG_RST_TEST_A      8'h31
`define GPCFG_RST_TEST_B      8'h88

`define GPCFG_BIT_DRIVE       7
`define GPCFG_BIT_TEMP        7
`define GPCFG_BIT_INV         6
`define GPCFG_BIT_RETAIN      6
`define GPCFG_FSEL_HI         5
`define GPCFG_FSEL_LO         0
`define GPCFG_ATTN_HI         5
`define GPCFG_ATTN_LO         4
`define GPCFG_THR_HI          3
`define GPCFG_THR_LO          0

`define GPCFG_FSEL_HIZ        6'h2e
`define GPCFG_FSEL_CLKDIV     6'h3f
`define GPCFG_CLK_DIV         192
`define GPCFG_CLK_HALF        8'd95

`define GPCFG_WAKE0_TEST_A    8'h31
`define GPCFG_WAKE0_TEST_B    8'h88
`define GPCFG_WAKE1_TEST_A    8'h35
`define GPCFG_WAKE1_TEST_B    8'h81

`define GPCFG_FIFO_SPAN       8'd65
`define GPCFG_CNT_W           7

`endif

/* gpcfg_thr.v */
// fifo fill threshold decode and compare, registered flags
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_map.vh"

module gpcfg_thr #(
    parameter CNT_W = `GPCFG_CNT_W
) (
    // clock and reset
    input  wire             i_clock,
    input  wire             i_arst_n,
    // setting and counts
    input  wire [3:0]       i_fill_threshold,
    input  wire [CNT_W-1:0] i_tx_count,
    input  wire [CNT_W-1:0] i_rx_count,
    // flags
    output reg              o_tx_reached,
    output reg              o_rx_reached
);
    wire [7:0] rx_thr;
    wire [7:0] tx_thr;
    wire [7:0] tx_cnt8;
    wire [7:0] rx_cnt8;

    // rx grows by four per step, tx mirrors it from the top of the fifo
    assign rx_thr  = {2'b00, i_fill_threshold, 2'b00} + 8'h04;
    assign tx_thr  = `GPCFG_FIFO_SPAN - rx_thr;
    assign tx_cnt8 = {{(8-CNT_W){1'b0}}, i_tx_count};
    assign rx_cnt8 = {{(8-CNT_W){1'b0}}, i_rx_count};

    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tx_reached <= 1'b0;
            o_rx_reached <= 1'b0;
        end else begin
            o_tx_reached <= (tx_cnt8 >= tx_thr);
            o_rx_reached <= (rx_cnt8 >= rx_thr);
        end
    end
endmodule
`default_nettype wire

/* gpcfg_top.v */
// output-pin and fifo threshold configuration registers with pin muxing and wake test load
// How it works
// - bit 7 of the pin-1 register picks high or low drive for all output pins together.
// - bit 6 of each pin register inverts that pin's selected signal, reset clear.
// - pin 1 function select resets to 0x2e, which leaves the pin undriven.
// - pin 0 function select resets to 0x3f, which drives the crystal clock divided by 192.
// - on wake from sleep the internal test settings load 0x31/0x88 or 0x35/0x81 by bit 6.
// - those loaded test values stay internal and reads of the test registers give reset values.
// - a fifo threshold flag is up when the byte count is at or above the threshold.
// - one four-bit field, reset 0111, sets both thresholds, 0 giving 61/4 and 1 giving 57/8.
`timescale 1ns/1ps
`default_nettype none
`include "gpcfg_map.vh"

module gpcfg_top #(
    parameter CNT_W     = `GPCFG_CNT_W,
    parameter CLK_DIV   = `GPCFG_CLK_DIV
) (
    // clock and reset
    input  wire              i_clock,
    input  wire              i_arst_n,
    // register port from the serial front end
    input  wire [5:0]        i_reg_addr,
    input  wire              i_reg_wr,
    input  wire [7:0]        i_reg_wdata,
    input  wire              i_reg_rd,
    output reg  [7:0]        o_reg_rdata,
    // candidate pin signals, same clock, one per function code
    input  wire [63:0]       i_func_sources,
    // output pins
    output reg               o_pin1_level,
    output reg               o_pin1_oe,
    output reg               o_pin0_level,
    output reg               o_pin0_oe,
    output wire              o_output_drive_strength,
    // analog and test controls
    output wire              o_temp_sensor_en,
    output wire [1:0]        o_rx_attenuation,
    input  wire              i_wake_pulse,
    output reg  [7:0]        o_test_setting_a,
    output reg  [7:0]        o_test_setting_b,
    // fifo fill
    input  wire [CNT_W-1:0]  i_tx_count,
    input  wire [CNT_W-1:0]  i_rx_count,
    output wire              o_tx_thr_reached,
    output wire              o_rx_thr_reached
);
    // last count of each half period, one less than CLK_DIV/2 system cycles, cut to the counter width on purpose
    localparam integer HALF_I = CLK_DIV / 2 - 1;
    localparam [7:0]   HALF   = HALF_I[7:0];

    reg  [7:0] pin1_cfg_r;
    reg  [7:0] pin0_cfg_r;
    reg  [7:0] fifo_cfg_r;
    reg  [7:0] div_cnt_r;
    reg        crystal_clock_div_r;
    reg  [7:0] rdata_nxt;

    wire [5:0] pin1_function_select = pin1_cfg_r[`GPCFG_FSEL_HI:`GPCFG_FSEL_LO];
    wire [5:0] pin0_function_select = pin0_cfg_r[`GPCFG_FSEL_HI:`GPCFG_FSEL_LO];
    wire       pin1_invert          = pin1_cfg_r[`GPCFG_BIT_INV];
    wire       pin0_invert          = pin0_cfg_r[`GPCFG_BIT_INV];
    wire       wake_test_retention  = fifo_cfg_r[`GPCFG_BIT_RETAIN];
    wire [3:0] fill_threshold       = fifo_cfg_r[`GPCFG_THR_HI:`GPCFG_THR_LO];

    // code 0x3f is served here, the rest come from the source vector
    function pick;
        input [5:0]  sel;
        input [63:0] src;
        input        divclk;
        begin
            if (sel == `GPCFG_FSEL_CLKDIV)
                pick = divclk;
            else
                pick = src[sel];
        end
    endfunction

    localparam [1:0] SEL_NONE = 2'd0;
    localparam [1:0] SEL_PIN1 = 2'd1;
    localparam [1:0] SEL_PIN0 = 2'd2;
    localparam [1:0] SEL_FIFO = 2'd3;

    // shared by write and read paths so both always agree on the map
    function [1:0] reg_sel;
        input [5:0] addr;
        begin
            case (addr)
                `GPCFG_OFS_PIN1: reg_sel = SEL_PIN1;
                `GPCFG_OFS_PIN0: reg_sel = SEL_PIN0;
                `GPCFG_OFS_FIFO: reg_sel = SEL_FIFO;
                default:         reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    // register writes; reserved bit 7 of the fifo register is stored as written
    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin1_cfg_r <= `GPCFG_RST_PIN1;
            pin0_cfg_r <= `GPCFG_RST_PIN0;
            fifo_cfg_r <= `GPCFG_RST_FIFO;
        end else if (i_reg_wr) begin
            case (reg_sel(i_reg_addr))
                SEL_PIN1: pin1_cfg_r <= i_reg_wdata;
                SEL_PIN0: pin0_cfg_r <= i_reg_wdata;
                SEL_FIFO: fifo_cfg_r <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // test registers read back reset values whatever was loaded on wake
    always @* begin
        rdata_nxt = 8'h00;
        case (reg_sel(i_reg_addr))
            SEL_PIN1: rdata_nxt = pin1_cfg_r;
            SEL_PIN0: rdata_nxt = pin0_cfg_r;
            SEL_FIFO: rdata_nxt = fifo_cfg_r;
            default: begin
                // not stored, so a read can never show what wake loaded
                if (i_reg_addr == `GPCFG_OFS_TEST_A)
                    rdata_nxt = `GPCFG_RST_TEST_A;
                else if (i_reg_addr == `GPCFG_OFS_TEST_B)
                    rdata_nxt = `GPCFG_RST_TEST_B;
                else
                    rdata_nxt = 8'h00;
            end
        endcase
    end

    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n)
            o_reg_rdata <= 8'h00;
        else if (i_reg_rd)
            o_reg_rdata <= rdata_nxt;
    end

    // internal test settings loaded at wake
    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_test_setting_a <= `GPCFG_RST_TEST_A;
            o_test_setting_b <= `GPCFG_RST_TEST_B;
        end else if (i_wake_pulse) begin
            if (wake_test_retention) begin
                o_test_setting_a <= `GPCFG_WAKE1_TEST_A;
                o_test_setting_b <= `GPCFG_WAKE1_TEST_B;
            end else begin
                o_test_setting_a <= `GPCFG_WAKE0_TEST_A;
                o_test_setting_b <= `GPCFG_WAKE0_TEST_B;
            end
        end
    end

    // divided crystal clock, half period of CLK_DIV/2 system cycles
    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_cnt_r           <= 8'h00;
            crystal_clock_div_r <= 1'b0;
        end else if (div_cnt_r == HALF) begin
            div_cnt_r           <= 8'h00;
            crystal_clock_div_r <= ~crystal_clock_div_r;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
        end
    end

    // each pin gets the same select, invert and drive-enable logic, fed from its own register fields
    wire [11:0] pin_sel_bus;
    wire [1:0]  pin_inv_bus;
    wire [1:0]  pin_level_nxt;
    wire [1:0]  pin_oe_nxt;

    assign pin_sel_bus = {pin1_function_select, pin0_function_select};
    assign pin_inv_bus = {pin1_invert, pin0_invert};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            wire [5:0] sel_w;
            assign sel_w             = pin_sel_bus[gi*6 +: 6];
            assign pin_level_nxt[gi] = pick(sel_w, i_func_sources, crystal_clock_div_r)
                                       ^ pin_inv_bus[gi];
            assign pin_oe_nxt[gi]    = (sel_w != `GPCFG_FSEL_HIZ);
        end
    endgenerate

    // pins registered so the divided clock stays glitch free when the select changes
    always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pin1_level <= 1'b0;
            o_pin1_oe    <= 1'b0;
            o_pin0_level <= 1'b0;
            o_pin0_oe    <= 1'b0;
        end else begin
            o_pin1_level <= pin_level_nxt[1];
            o_pin0_level <= pin_level_nxt[0];
            o_pin1_oe    <= pin_oe_nxt[1];
            o_pin0_oe    <= pin_oe_nxt[0];
        end
    end

    assign o_output_drive_strength = pin1_cfg_r[`GPCFG_BIT_DRIVE];
    // sensor bit alone; keeping the other bits zero is up to the host
    assign o_temp_sensor_en        = pin0_cfg_r[`GPCFG_BIT_TEMP];
    assign o_rx_attenuation        = fifo_cfg_r[`GPCFG_ATTN_HI:`GPCFG_ATTN_LO];

    gpcfg_thr #(
        .CNT_W            (CNT_W)
    ) u_thr (
        .i_clock          (i_clock),
        .i_arst_n         (i_arst_n),
        .i_fill_threshold (fill_threshold),
        .i_tx_count       (i_tx_count),
        .i_rx_count       (i_rx_count),
        .o_tx_reached     (o_tx_thr_reached),
        .o_rx_reached     (o_rx_thr_reached)
    );
endmodule
`default_nettype wire

/* gpcfg_chk.sv */
// assertions on register port, wake load and fifo flags
`timescale 1ns/1ps
`default_nettype none
module gpcfg_chk #(parameter CNT_W = 7) (
    // register port and test values
    input wire logic [5:0]       i_reg_addr,
    input wire logic [7:0]       i_reg_wdata,
    input wire logic [7:0]       o_reg_rdata,
    input wire logic [7:0]       o_test_setting_a,
    input wire logic [7:0]       o_test_setting_b,
    // fifo counts
    input wire logic [CNT_W-1:0] i_tx_count,
    input wire logic [CNT_W-1:0] i_rx_count,
    // strobes, pins and flags
    input wire logic             i_clock,
    input wire logic             i_arst_n,
    input wire logic             i_reg_wr,
    input wire logic             i_reg_rd,
    input wire logic             i_wake_pulse,
    input wire logic             o_pin1_oe,
    input wire logic             o_output_drive_strength,
    input wire logic             o_tx_thr_reached,
    input wire logic             o_rx_thr_reached
);
    logic [3:0] thr_r;
    logic       retain_r;
    logic       rx_exp_r;
    logic       tx_exp_r;
    // mirror of the threshold field, flags judged without a read
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            thr_r <= 4'h7;
            retain_r <= 1'b0;
            rx_exp_r <= 1'b0;
            tx_exp_r <= 1'b0;
        end else begin
            if (i_reg_wr && i_reg_addr == 6'h03) begin
                thr_r <= i_reg_wdata[3:0];
                retain_r <= i_reg_wdata[6];
            end
            rx_exp_r <= int'(i_rx_count) >= 4 * (int'(thr_r) + 1);
            tx_exp_r <= int'(i_tx_count) >= 61 - 4 * int'(thr_r);
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    sequence s_wr_pin1;
        i_reg_wr && i_reg_addr == 6'h01;
    endsequence
    sequence s_wake_plain;
        i_wake_pulse && !retain_r;
    endsequence
    sequence s_wake_retain;
        i_wake_pulse && retain_r;
    endsequence
    a_drive_follow: assert property (s_wr_pin1 |=>
        o_output_drive_strength == $past(i_reg_wdata[7]))
        else $error("drive strength wrong");
    a_pin1_hiz: assert property (s_wr_pin1 ##0 i_reg_wdata[5:0] == 6'h2e |=> ##1 !o_pin1_oe)
        else $error("pin 1 still driven");
    a_pin1_on: assert property (s_wr_pin1 ##0 i_reg_wdata[5:0] != 6'h2e |=> ##1 o_pin1_oe)
        else $error("pin 1 not driven");
    a_wake_load: assert property (s_wake_plain |=>
        o_test_setting_a == 8'h31 && o_test_setting_b == 8'h88)
        else $error("wake values wrong");
    a_wake_retain: assert property (s_wake_retain |=>
        o_test_setting_a == 8'h35 && o_test_setting_b == 8'h81)
        else $error("retained wake values wrong");
    a_wake_hold: assert property (!i_wake_pulse |=>
        $stable(o_test_setting_a) && $stable(o_test_setting_b))
        else $error("test values moved");
    a_test_a_read: assert property (i_reg_rd && i_reg_addr == 6'h2d |=> o_reg_rdata == 8'h31)
        else $error("test a read wrong");
    a_test_b_read: assert property (i_reg_rd && i_reg_addr == 6'h2c |=> o_reg_rdata == 8'h88)
        else $error("test b read wrong");
    a_rx_flag: assert property (o_rx_thr_reached == rx_exp_r) else $error("rx flag wrong");
    a_tx_flag: assert property (o_tx_thr_reached == tx_exp_r) else $error("tx flag wrong");
endmodule
bind gpcfg_top gpcfg_chk #(
    .CNT_W                   (CNT_W)
) u_chk (
    .i_reg_addr              (i_reg_addr),
    .i_reg_wdata             (i_reg_wdata),
    .o_reg_rdata             (o_reg_rdata),
    .o_test_setting_a        (o_test_setting_a),
    .o_test_setting_b        (o_test_setting_b),
    .i_tx_count              (i_tx_count),
    .i_rx_count              (i_rx_count),
    .i_clock                 (i_clock),
    .i_arst_n                (i_arst_n),
    .i_reg_wr                (i_reg_wr),
    .i_reg_rd                (i_reg_rd),
    .i_wake_pulse            (i_wake_pulse),
    .o_pin1_oe               (o_pin1_oe),
    .o_output_drive_strength (o_output_drive_strength),
    .o_tx_thr_reached        (o_tx_thr_reached),
    .o_rx_thr_reached        (o_rx_thr_reached)
);
`default_nettype wire

/* gpcfg_host.sv */
// host model driving the register port one byte at a time
`timescale 1ns/1ps
`default_nettype none
module gpcfg_host (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    output var logic [5:0]  o_addr = 6'h00,
    output var logic        o_wr = 1'b0,
    output var logic        o_rd = 1'b0,
    output var logic [7:0]  o_wdata = 8'h00
);
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clock) #1;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_clock) #1;
        o_wr = 1'b0;
        // released data must not keep looking valid
        o_wdata = ~d;
    endtask
    task rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_clock) #1;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_clock) #1;
        o_rd = 1'b0;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

/* gpcfg_tb.sv */
// testbench for the output-pin and fifo threshold config block
`timescale 1ns/1ps
`default_nettype none
module gp_output_and_fifo_threshold_cfg_tb;
    logic        i_clock, i_arst_n, i_reg_wr, i_reg_rd, i_wake_pulse;
    logic        o_pin1_level, o_pin1_oe, o_pin0_level, o_pin0_oe, o_output_drive_strength;
    logic        o_temp_sensor_en, o_tx_thr_reached, o_rx_thr_reached;
    logic [1:0]  o_rx_attenuation;
    logic [5:0]  i_reg_addr;
    logic [7:0]  i_reg_wdata, o_reg_rdata, o_test_setting_a, o_test_setting_b, rd_v;
    logic [63:0] i_func_sources;
    logic [6:0]  i_tx_count, i_rx_count;
    int          errors, n_checks, cyc;
    gpcfg_top dut (
        .i_clock                 (i_clock),
        .i_arst_n                (i_arst_n),
        .i_reg_addr              (i_reg_addr),
        .i_reg_wr                (i_reg_wr),
        .i_reg_wdata             (i_reg_wdata),
        .i_reg_rd                (i_reg_rd),
        .o_reg_rdata             (o_reg_rdata),
        .i_func_sources          (i_func_sources),
        .o_pin1_level            (o_pin1_level),
        .o_pin1_oe               (o_pin1_oe),
        .o_pin0_level            (o_pin0_level),
        .o_pin0_oe               (o_pin0_oe),
        .o_output_drive_strength (o_output_drive_strength),
        .o_temp_sensor_en        (o_temp_sensor_en),
        .o_rx_attenuation        (o_rx_attenuation),
        .i_wake_pulse            (i_wake_pulse),
        .o_test_setting_a        (o_test_setting_a),
        .o_test_setting_b        (o_test_setting_b),
        .i_tx_count              (i_tx_count),
        .i_rx_count              (i_rx_count),
        .o_tx_thr_reached        (o_tx_thr_reached),
        .o_rx_thr_reached        (o_rx_thr_reached)
    );
    gpcfg_host host (.i_clock(i_clock), .i_rdata(o_reg_rdata), .o_addr(i_reg_addr),
                     .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata));
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            close_out;
        end
    end
    task close_out;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rchk(input logic [5:0] a, input logic [7:0] e);
        host.rd(a, rd_v);
        chk(rd_v, e);
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task t_reset;
        logic lvl;
        rchk(6'h01, 8'h2e);
        rchk(6'h02, 8'h3f);
        rchk(6'h03, 8'h07);
        rchk(6'h3e, 8'h00);
        chk(o_pin1_oe, 8'h00);
        chk(o_pin0_oe, 8'h01);
        chk(o_output_drive_strength, 8'h00);
        // divided clock must invert every 96 cycles whatever its phase
        lvl = o_pin0_level;
        tick(96);
        chk(o_pin0_level, {7'h00, ~lvl});
        tick(96);
        chk(o_pin0_level, {7'h00, lvl});
    endtask
    task t_pins;
        i_func_sources = 64'h0000_0000_0000_0020;
        host.wr(6'h01, 8'hc5);
        host.wr(6'h02, 8'h05);
        tick(2);
        chk(o_output_drive_strength, 8'h01);
        chk(o_pin1_level, 8'h00);
        chk(o_pin0_level, 8'h01);
        chk(o_pin1_oe, 8'h01);
        host.wr(6'h02, 8'h80);
        host.wr(6'h01, 8'h2e);
        tick(2);
        chk(o_pin1_oe, 8'h00);
        chk(o_temp_sensor_en, 8'h01);
    endtask
    task t_wake(input logic [7:0] cfg, input logic [7:0] ea, input logic [7:0] eb);
        host.wr(6'h03, cfg);
        host.wr(6'h2d, 8'h00);
        i_wake_pulse = 1'b1;
        tick(1);
        i_wake_pulse = 1'b0;
        chk(o_test_setting_a, ea);
        chk(o_test_setting_b, eb);
        chk(o_rx_attenuation, {6'h00, cfg[5:4]});
        rchk(6'h2d, 8'h31);
        rchk(6'h2c, 8'h88);
    endtask
    task t_thr;
        int n, rx;
        for (n = 0; n < 16; n++) begin
            rx = 4 * (n + 1);
            host.wr(6'h03, n[7:0]);
            i_rx_count = 7'(rx - 1);
            i_tx_count = 7'(64 - rx);
            tick(2);
            chk(o_rx_thr_reached, 8'h00);
            chk(o_tx_thr_reached, 8'h00);
            i_rx_count = 7'(rx);
            i_tx_count = 7'(65 - rx);
            tick(1);
            chk(o_rx_thr_reached, 8'h01);
            chk(o_tx_thr_reached, 8'h01);
        end
    endtask
    initial begin
        i_arst_n = 1'b0;
        i_wake_pulse = 1'b0;
        i_func_sources = 64'h0;
        i_tx_count = 7'h00;
        i_rx_count = 7'h00;
        errors = 0;
        n_checks = 0;
        cyc = 0;
        repeat (6) @(posedge i_clock);
        #1 i_arst_n = 1'b1;
        t_reset;
        t_pins;
        t_wake(8'h67, 8'h35, 8'h81);
        t_wake(8'h07, 8'h31, 8'h88);
        t_thr;
        close_out;
    end
endmodule
`default_nettype wire
